// ===== include/crt_pkg.sv
// constants, codes and types shared by the raster refresh controller
package crt_pkg;

  // ****************************************
  // widths and sizes
  // ****************************************
  localparam int DW         = 8;
  localparam int CW         = 7;
  localparam int LW         = 4;
  localparam int BUF_LEN    = 128;
  localparam int FIFO_DEPTH = 16;
  localparam int FRAME_W    = 5;

  // ****************************************
  // command codes, taken from data bits 7:5
  // ****************************************
  localparam logic [2:0] CMD_RESET   = 3'h0;
  localparam logic [2:0] CMD_START   = 3'h1;
  localparam logic [2:0] CMD_STOP    = 3'h2;
  localparam logic [2:0] CMD_CURSOR  = 3'h4;
  localparam logic [2:0] CMD_INT_EN  = 3'h5;
  localparam logic [2:0] CMD_INT_DIS = 3'h6;

  // ****************************************
  // status byte bit positions
  // ****************************************
  localparam int ST_FO = 0;
  localparam int ST_DU = 1;
  localparam int ST_VE = 2;
  localparam int ST_IR = 3;
  localparam int ST_IE = 4;

  // ****************************************
  // format reset values (count minus one)
  // ****************************************
  localparam logic [6:0] RST_CHARS = 7'h4f;
  localparam logic [4:0] RST_HRET  = 5'h0f;
  localparam logic [3:0] RST_LINES = 4'h9;
  localparam logic [5:0] RST_ROWS  = 6'h18;
  localparam logic [1:0] RST_VRET  = 2'h1;

  // ****************************************
  // display data codes and attribute fields
  // ****************************************
  localparam logic [7:0] CODE_EOR  = 8'hf0;
  localparam logic [7:0] CODE_EOS  = 8'hf2;
  localparam logic [1:0] ATTR_TAG  = 2'h2;
  localparam int         AT_HL     = 0;
  localparam int         AT_BLINK  = 1;
  localparam int         AT_GPA    = 2;
  localparam int         AT_UL     = 5;
  localparam int         CUR_BLINK_BIT  = 3;
  localparam int         ATTR_BLINK_BIT = 4;

  typedef enum logic [1:0] {PM_IDLE, PM_RESET, PM_CURSOR} crt_pmode_t;

endpackage

// ===== verilog/crt_fifo.sv
// first-in first-out buffer with valid and ready on both sides
`timescale 1ns/1ns
module crt_fifo
#(
  parameter int W = 8,
  parameter int D = 16
)
(
  input  wire logic         clk,
  input  wire logic         rst_b,
  input  wire logic [W-1:0] in_data,
  input  wire logic         in_valid,
  output logic              in_ready,
  output logic      [W-1:0] out_data,
  output logic              out_valid,
  input  wire logic         out_ready
);

  localparam int AW = $clog2(D);

  logic [W-1:0] mem_r [D];
  logic [AW-1:0] wp_r, wp_nxt;
  logic [AW-1:0] rp_r, rp_nxt;
  logic [AW:0]   cnt_r, cnt_nxt;
  logic          push;
  logic          pop;

  // ****************************************
  // pointers and fill level
  // ****************************************
  always_comb
  begin
    in_ready  = cnt_r != (AW+1)'(D);
    out_valid = cnt_r != '0;
    out_data  = mem_r[rp_r];
    push      = in_valid && in_ready;
    pop       = out_valid && out_ready;
    wp_nxt    = push ? ((wp_r == AW'(D - 1)) ? '0 : wp_r + AW'(1)) : wp_r;
    rp_nxt    = pop ? ((rp_r == AW'(D - 1)) ? '0 : rp_r + AW'(1)) : rp_r;
    cnt_nxt   = cnt_r + (AW+1)'(push) - (AW+1)'(pop);
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      wp_r  <= '0;
      rp_r  <= '0;
      cnt_r <= '0;
    end
    else
    begin
      wp_r  <= wp_nxt;
      rp_r  <= rp_nxt;
      cnt_r <= cnt_nxt;
    end
  end

  always_ff @(posedge clk)
  begin
    if (push)
      mem_r[wp_r] <= in_data;
  end

endmodule // crt_fifo

// ===== verilog/crt_refresh.sv
// raster refresh controller: host port, row buffers, raster timing and video controls
//
// Behaviour
// - horiz_retrace high through horizontal retrace; video_suppress high, light_enable low.
// - vert_retrace high through vertical retrace; video_suppress high, light_enable low.
// - line_count shows the internal line counter for the character generator.
// - row_buffer_ready high while a row buffer can take character data.
// - character data written only while row buffer select is active.
// - port select high reaches command port, low reaches parameter port.
// - status reads and command or parameter writes need chip select.
// - data lines driven only during a read of the command or parameter port.
// - char_code comes from the row buffer being displayed.
// - highlight high where field attributes ask for intensification.
// - general_attr follows the general purpose field attribute codes.
// - interrupt output goes high when service is needed.
// - suppress video in retrace, end codes, underrun, and blink at 1/16, 1/32.
// - character counter sets characters per row and horizontal retrace length.
`timescale 1ns/1ns
module crt_refresh
(
  input  wire logic                 clk,
  input  wire logic                 rst_b,
  input  wire logic                 port_select,
  input  wire logic                 rd_b,
  input  wire logic                 wr_b,
  input  wire logic                 cs_b,
  input  wire logic                 row_buffer_select_b,
  input  wire logic [crt_pkg::DW-1:0] data_lines_in,
  output logic      [crt_pkg::DW-1:0] data_lines_out,
  output logic                      data_lines_oe,
  output logic                      row_buffer_ready,
  output logic                      interrupt,
  output logic      [crt_pkg::LW-1:0] line_count,
  output logic      [crt_pkg::CW-1:0] char_code,
  output logic                      horiz_retrace,
  output logic                      vert_retrace,
  output logic                      video_suppress,
  output logic                      light_enable,
  output logic                      highlight,
  output logic      [1:0]           general_attr
);
  import crt_pkg::*;

  // ****************************************
  // declarations
  // ****************************************
  logic            rd_d_r, wr_d_r;
  logic            ve_r, ve_nxt, ie_r, ie_nxt, ir_r, ir_nxt;
  logic            du_r, du_nxt, fo_r, fo_nxt;
  crt_pmode_t      pmode_r, pmode_nxt;
  logic            pidx_r, pidx2_r;
  logic [1:0]      pcnt_r, pcnt_nxt;
  logic [6:0]      chars_r, chars_nxt, cur_col_r, cur_col_nxt;
  logic [4:0]      hret_r, hret_nxt;
  logic [3:0]      lines_r, lines_nxt;
  logic [5:0]      rows_r, rows_nxt, cur_row_r, cur_row_nxt;
  logic [1:0]      vret_r, vret_nxt;
  logic [DW-1:0]   dout_r, dout_nxt;
  logic            oe_r, oe_nxt, int_r, int_nxt, rdy_r, rdy_nxt;
  logic            rd_start, wr_start, cmd_wr, par_wr, row_wr, stat_rd, reset_cmd;

  logic [7:0]      char_cnt_r, char_cnt_nxt, last_char;
  logic [3:0]      line_cnt_r, line_cnt_nxt;
  logic [6:0]      row_cnt_r, row_cnt_nxt, last_row;
  logic [FRAME_W-1:0] frame_r, frame_nxt;
  logic            line_end, row_end, frame_end, in_hret, in_vret, vret_start, swap_evt;

  logic [DW-1:0]   rowbuf_r [2][BUF_LEN];
  logic            show_sel_r, show_sel_nxt, under_r, under_nxt;
  logic [7:0]      fill_cnt_r, fill_cnt_nxt;
  logic            fill_done, underrun_evt;
  logic            fifo_in_ready, fifo_out_valid, fifo_out_ready;
  logic [DW-1:0]   fifo_out_data;

  logic [5:0]      attr_cur_r, attr_cur_nxt, attr_row_r, attr_row_nxt, attr_now;
  logic            eol_r, eol_nxt, eos_line_r, eos_line_nxt, eos_rows_r, eos_rows_nxt;
  logic [DW-1:0]   ch;
  logic            active, is_attr, is_eor, is_eos, blank_char, blink, cur_hit;
  logic [LW-1:0]   lc_r, lc_nxt;
  logic [CW-1:0]   cc_r, cc_nxt;
  logic            hr_r, hr_nxt, vr_r, vr_nxt, vsp_r, vsp_nxt, light_enable_r, light_enable_nxt, hl_r, hl_nxt;
  logic [1:0]      gpa_r, gpa_nxt;

  // ****************************************
  // host port
  // ****************************************
  always_comb
  begin
    rd_start  = rd_d_r && !rd_b;
    wr_start  = wr_d_r && !wr_b;
    cmd_wr    = wr_start && !cs_b && row_buffer_select_b && port_select;
    par_wr    = wr_start && !cs_b && row_buffer_select_b && !port_select;
    row_wr    = wr_start && cs_b && !row_buffer_select_b;
    stat_rd   = rd_start && !cs_b && row_buffer_select_b && port_select;
    reset_cmd = cmd_wr && data_lines_in[7:5] == CMD_RESET;
    ve_nxt = ve_r; ie_nxt = ie_r; ir_nxt = ir_r; du_nxt = du_r; fo_nxt = fo_r;
    pmode_nxt = pmode_r; pcnt_nxt = pcnt_r;
    chars_nxt = chars_r; hret_nxt = hret_r; lines_nxt = lines_r;
    rows_nxt = rows_r; vret_nxt = vret_r; cur_col_nxt = cur_col_r; cur_row_nxt = cur_row_r;
    dout_nxt = dout_r;
    if (rd_start)
      dout_nxt = stat_rd ? {3'h0, ie_r, ir_r, ve_r, du_r, fo_r} : '0;
    oe_nxt = !rd_b && !cs_b && row_buffer_select_b;
    if (stat_rd)
    begin
      ir_nxt = 1'b0;
      du_nxt = 1'b0;
      fo_nxt = 1'b0;
    end
    if (cmd_wr)
    begin
      pcnt_nxt = '0;
      unique case (data_lines_in[7:5])
        CMD_RESET:   begin ve_nxt = 1'b0; pmode_nxt = PM_RESET; end
        CMD_START:   ve_nxt = 1'b1;
        CMD_STOP:    ve_nxt = 1'b0;
        CMD_CURSOR:  pmode_nxt = PM_CURSOR;
        CMD_INT_EN:  ie_nxt = 1'b1;
        CMD_INT_DIS: ie_nxt = 1'b0;
        default:     pmode_nxt = PM_IDLE;
      endcase
    end
    else if (par_wr)
    begin
      pcnt_nxt = pcnt_r + 2'h1;
      unique case (pmode_r)
        PM_IDLE: pcnt_nxt = pcnt_r;
        PM_RESET:
        begin
          unique case (pcnt_r)
            2'h0: chars_nxt = data_lines_in[6:0];
            2'h1: begin vret_nxt = data_lines_in[7:6]; rows_nxt = data_lines_in[5:0]; end
            2'h2: lines_nxt = data_lines_in[3:0];
            2'h3: begin hret_nxt = data_lines_in[4:0]; pmode_nxt = PM_IDLE; end
          endcase
        end
        PM_CURSOR:
        begin
          if (pcnt_r == 2'h0)
            cur_col_nxt = data_lines_in[6:0];
          else
          begin
            cur_row_nxt = data_lines_in[5:0];
            pmode_nxt   = PM_IDLE;
          end
        end
      endcase
    end
    if (vret_start)
      ir_nxt = 1'b1;
    if (underrun_evt)
      du_nxt = 1'b1;
    if (row_wr && !fifo_in_ready)
      fo_nxt = 1'b1;
    int_nxt = ir_nxt && ie_nxt;
    rdy_nxt = ve_nxt && fifo_in_ready && !under_r;
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      rd_d_r <= 1'b1; wr_d_r <= 1'b1;
      ve_r <= 1'b0; ie_r <= 1'b0; ir_r <= 1'b0; du_r <= 1'b0; fo_r <= 1'b0;
      pmode_r <= PM_IDLE; pcnt_r <= '0;
      chars_r <= RST_CHARS; hret_r <= RST_HRET; lines_r <= RST_LINES;
      rows_r <= RST_ROWS; vret_r <= RST_VRET; cur_col_r <= '0; cur_row_r <= '0;
      dout_r <= '0; oe_r <= 1'b0; int_r <= 1'b0; rdy_r <= 1'b0;
    end
    else
    begin
      rd_d_r <= rd_b; wr_d_r <= wr_b;
      ve_r <= ve_nxt; ie_r <= ie_nxt; ir_r <= ir_nxt; du_r <= du_nxt; fo_r <= fo_nxt;
      pmode_r <= pmode_nxt; pcnt_r <= pcnt_nxt;
      chars_r <= chars_nxt; hret_r <= hret_nxt; lines_r <= lines_nxt;
      rows_r <= rows_nxt; vret_r <= vret_nxt; cur_col_r <= cur_col_nxt; cur_row_r <= cur_row_nxt;
      dout_r <= dout_nxt; oe_r <= oe_nxt; int_r <= int_nxt; rdy_r <= rdy_nxt;
    end
  end

  // ****************************************
  // raster counters
  // ****************************************
  always_comb
  begin
    last_char  = {1'b0, chars_r} + {3'h0, hret_r} + 8'h01;
    last_row   = {1'b0, rows_r} + {5'h00, vret_r} + 7'h01;
    line_end   = char_cnt_r == last_char;
    row_end    = line_end && line_cnt_r == lines_r;
    frame_end  = row_end && row_cnt_r == last_row;
    in_hret    = char_cnt_r > {1'b0, chars_r};
    in_vret    = row_cnt_r > {1'b0, rows_r};
    vret_start = row_end && row_cnt_r == {1'b0, rows_r};
    swap_evt   = ve_r && row_end && (frame_end || row_cnt_r < {1'b0, rows_r});
    char_cnt_nxt = line_end ? 8'h00 : char_cnt_r + 8'h01;
    line_cnt_nxt = row_end ? 4'h0 : (line_end ? line_cnt_r + 4'h1 : line_cnt_r);
    row_cnt_nxt  = frame_end ? 7'h00 : (row_end ? row_cnt_r + 7'h01 : row_cnt_r);
    frame_nxt    = frame_end ? frame_r + FRAME_W'(1) : frame_r;
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      char_cnt_r <= '0; line_cnt_r <= '0; row_cnt_r <= '0; frame_r <= '0;
    end
    else
    begin
      char_cnt_r <= char_cnt_nxt; line_cnt_r <= line_cnt_nxt;
      row_cnt_r <= row_cnt_nxt; frame_r <= frame_nxt;
    end
  end

  // ****************************************
  // row buffer loading and swap
  // ****************************************
  crt_fifo #(.W(DW), .D(FIFO_DEPTH)) u_fifo
  (
    .clk       (clk),
    .rst_b     (rst_b),
    .in_data   (data_lines_in),
    .in_valid  (row_wr),
    .in_ready  (fifo_in_ready),
    .out_data  (fifo_out_data),
    .out_valid (fifo_out_valid),
    .out_ready (fifo_out_ready)
  );

  always_comb
  begin
    fill_done      = fill_cnt_r == {1'b0, chars_r} + 8'h01;
    fifo_out_ready = ve_r && !fill_done;
    underrun_evt   = swap_evt && !fill_done;
    show_sel_nxt   = show_sel_r;
    fill_cnt_nxt   = fill_cnt_r;
    under_nxt      = vret_start ? 1'b0 : under_r;
    if (fifo_out_valid && fifo_out_ready)
      fill_cnt_nxt = fill_cnt_r + 8'h01;
    if (swap_evt && fill_done)
    begin
      show_sel_nxt = !show_sel_r;
      fill_cnt_nxt = 8'h00;
    end
    if (underrun_evt)
      under_nxt = 1'b1;
    if (reset_cmd)
      fill_cnt_nxt = 8'h00;
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      show_sel_r <= 1'b0; fill_cnt_r <= '0; under_r <= 1'b0;
    end
    else
    begin
      show_sel_r <= show_sel_nxt; fill_cnt_r <= fill_cnt_nxt; under_r <= under_nxt;
    end
  end

  always_ff @(posedge clk)
  begin
    if (fifo_out_valid && fifo_out_ready)
      rowbuf_r[!show_sel_r][fill_cnt_r[6:0]] <= fifo_out_data;
  end

  // ****************************************
  // video controls
  // ****************************************
  always_comb
  begin
    ch         = rowbuf_r[show_sel_r][char_cnt_r[6:0]];
    active     = !in_hret && !in_vret;
    is_attr    = ch[7:6] == ATTR_TAG;
    is_eor     = ch == CODE_EOR;
    is_eos     = ch == CODE_EOS;
    attr_now   = (active && is_attr) ? ch[5:0] : attr_cur_r;
    cur_hit    = char_cnt_r[6:0] == cur_col_r && row_cnt_r == {1'b0, cur_row_r};
    blank_char = !ve_r || under_r || eol_r || eos_rows_r || is_attr || is_eor || is_eos;
    blink      = (attr_now[AT_BLINK] && frame_r[ATTR_BLINK_BIT])
                 || (cur_hit && frame_r[CUR_BLINK_BIT]);
    attr_cur_nxt = attr_now;
    attr_row_nxt = attr_row_r;
    eol_nxt      = eol_r || (active && (is_eor || is_eos));
    eos_line_nxt = eos_line_r || (active && is_eos);
    eos_rows_nxt = eos_rows_r;
    if (line_end)
    begin
      eol_nxt      = 1'b0;
      eos_line_nxt = 1'b0;
      attr_cur_nxt = row_end ? attr_cur_r : attr_row_r;
      if (row_end)
      begin
        attr_row_nxt = attr_cur_r;
        eos_rows_nxt = eos_rows_r || eos_line_r;
      end
    end
    if (frame_end)
    begin
      attr_cur_nxt = '0;
      attr_row_nxt = '0;
      eos_rows_nxt = 1'b0;
    end
    lc_nxt   = line_cnt_r;
    cc_nxt   = ch[CW-1:0];
    hr_nxt   = in_hret;
    vr_nxt   = in_vret;
    vsp_nxt  = !active || blank_char || blink;
    light_enable_nxt = active && !blank_char && attr_now[AT_UL] && line_cnt_r == lines_r;
    hl_nxt   = active && !blank_char && attr_now[AT_HL];
    gpa_nxt  = active ? attr_now[AT_GPA+1:AT_GPA] : 2'h0;
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      attr_cur_r <= '0; attr_row_r <= '0; eol_r <= 1'b0; eos_line_r <= 1'b0; eos_rows_r <= 1'b0;
      lc_r <= '0; cc_r <= '0; hr_r <= 1'b0; vr_r <= 1'b0; vsp_r <= 1'b1;
      light_enable_r <= 1'b0; hl_r <= 1'b0; gpa_r <= '0;
    end
    else
    begin
      attr_cur_r <= attr_cur_nxt; attr_row_r <= attr_row_nxt; eol_r <= eol_nxt;
      eos_line_r <= eos_line_nxt; eos_rows_r <= eos_rows_nxt;
      lc_r <= lc_nxt; cc_r <= cc_nxt; hr_r <= hr_nxt; vr_r <= vr_nxt; vsp_r <= vsp_nxt;
      light_enable_r <= light_enable_nxt; hl_r <= hl_nxt; gpa_r <= gpa_nxt;
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  assign data_lines_out   = dout_r;
  assign data_lines_oe    = oe_r;
  assign row_buffer_ready = rdy_r;
  assign interrupt        = int_r;
  assign line_count       = lc_r;
  assign char_code        = cc_r;
  assign horiz_retrace    = hr_r;
  assign vert_retrace     = vr_r;
  assign video_suppress   = vsp_r;
  assign light_enable     = light_enable_r;
  assign highlight        = hl_r;
  assign general_attr     = gpa_r;

endmodule // crt_refresh

// ===== tb/crt_refresh_sva.sv
// port assertions for the raster refresh controller
`timescale 1ns/1ns
module crt_refresh_sva
(
  input wire logic                   clk,
  input wire logic                   rst_b,
  input wire logic                   port_select,
  input wire logic                   rd_b,
  input wire logic                   wr_b,
  input wire logic                   cs_b,
  input wire logic                   row_buffer_select_b,
  input wire logic [crt_pkg::DW-1:0] data_lines_out,
  input wire logic                   data_lines_oe,
  input wire logic [crt_pkg::LW-1:0] line_count,
  input wire logic                   horiz_retrace,
  input wire logic                   vert_retrace,
  input wire logic                   video_suppress,
  input wire logic                   light_enable
);
  import crt_pkg::*;

  // ****************************************
  // cycles since the last chip-selected host write
  // ****************************************
  logic [7:0] quiet_r;
  logic [7:0] quiet_nxt;

  always_comb
  begin
    quiet_nxt = quiet_r;
    if (!wr_b && !cs_b)
      quiet_nxt = 8'h00;
    else if (quiet_r != 8'hff)
      quiet_nxt = quiet_r + 8'h01;
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      quiet_r <= 8'h00;
    else
      quiet_r <= quiet_nxt;
  end

  // ****************************************
  // assertions
  // ****************************************
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_b);

  property p_hret_blank;
    horiz_retrace |-> video_suppress && !light_enable;
  endproperty
  a_hret_blank: assert property (p_hret_blank)
    else $error("video not blanked in horizontal retrace");

  property p_vret_blank;
    vert_retrace |-> video_suppress && !light_enable;
  endproperty
  a_vret_blank: assert property (p_vret_blank)
    else $error("video not blanked in vertical retrace");

  property p_oe_cause;
    data_lines_oe |-> !$past(rd_b) && !$past(cs_b) && $past(row_buffer_select_b);
  endproperty
  a_oe_cause: assert property (p_oe_cause)
    else $error("data lines driven outside a read");

  property p_rd_answer;
    $fell(rd_b) && !cs_b && row_buffer_select_b |=> data_lines_oe;
  endproperty
  a_rd_answer: assert property (p_rd_answer)
    else $error("selected read not answered");

  property p_resv_zero;
    $fell(rd_b) && !cs_b && row_buffer_select_b && !port_select |=> data_lines_out == 8'h00;
  endproperty
  a_resv_zero: assert property (p_resv_zero)
    else $error("parameter port read not zero");

  property p_no_cs;
    !rd_b && cs_b |=> !data_lines_oe;
  endproperty
  a_no_cs: assert property (p_no_cs)
    else $error("read answered without chip select");

  property p_wr_quiet;
    !wr_b && rd_b |=> !data_lines_oe [*2];
  endproperty
  a_wr_quiet: assert property (p_wr_quiet)
    else $error("bus driven after a write");

  property p_lc_align;
    $changed(line_count) && quiet_r == 8'hff |-> $fell(horiz_retrace);
  endproperty
  a_lc_align: assert property (p_lc_align)
    else $error("line count moved off the line boundary");

  property p_vr_align;
    $changed(vert_retrace) && quiet_r == 8'hff |-> $fell(horiz_retrace);
  endproperty
  a_vr_align: assert property (p_vr_align)
    else $error("vertical retrace moved off the line boundary");
endmodule // crt_refresh_sva

// ===== tb/crt_host_model.sv
// host bus model: strobed accesses and data line resolution
`timescale 1ns/1ns
module crt_host_model
(
  input  wire logic                   clk,
  input  wire logic [crt_pkg::DW-1:0] data_lines_out,
  input  wire logic                   data_lines_oe,
  output logic                        port_select,
  output logic                        rd_b,
  output logic                        wr_b,
  output logic                        cs_b,
  output logic                        row_buffer_select_b,
  output logic      [crt_pkg::DW-1:0] data_lines_in
);
  import crt_pkg::*;

  // ****************************************
  // bus model
  // ****************************************
  logic [DW-1:0] drv_r;
  logic [DW-1:0] idle_r;
  logic          drv_en;

  // released lines toggle every cycle
  assign data_lines_in = data_lines_oe ? data_lines_out : drv_en ? drv_r : idle_r;
  always @(posedge clk) idle_r <= ~data_lines_in;

  initial
  begin
    {rd_b, wr_b, cs_b, row_buffer_select_b, port_select, drv_en} = 6'b111100;
    drv_r = 8'h00;
    idle_r = 8'h5a;
  end

  // strobe low for one sampled edge, then release everything but port_select
  task automatic acc(input logic ps, input logic cs, input logic bs, input logic rd, input logic [DW-1:0] d);
    @(posedge clk);
    #2;
    port_select = ps;
    cs_b = cs;
    row_buffer_select_b = bs;
    drv_r = d;
    drv_en = !rd;
    rd_b = !rd;
    wr_b = rd;
    @(posedge clk);
    #2;
    {rd_b, wr_b, cs_b, row_buffer_select_b, drv_en} = 5'b11110;
  endtask
endmodule // crt_host_model

// ===== tb/testbench.sv
// self-checking bench for the raster refresh controller
`timescale 1ns/1ns
module testbench;
  import crt_pkg::*;
  logic          clk = 1'b0;
  logic          rst_b = 1'b0;
  logic          port_select, rd_b, wr_b, cs_b, row_buffer_select_b;
  logic [DW-1:0] data_lines_in, data_lines_out;
  logic          data_lines_oe, row_buffer_ready, interrupt, horiz_retrace, vert_retrace;
  logic          video_suppress, light_enable, highlight;
  logic [LW-1:0] line_count;
  logic [LW-1:0] max_lc = 4'h0;
  logic [CW-1:0] char_code, ch;
  logic [1:0]    general_attr, gpa;
  logic [15:0]   exp_q[$];
  logic [15:0]   e;
  logic [31:0]   rs = 32'h878c;
  logic          oe_q = 1'b0;
  logic          mon_on = 1'b0;
  int            error_cnt = 0, num_checks = 0, vis = 0, li = 0, n;
  logic [8:0]    cfg[7] = '{9'h100, 9'h007, 9'h001, 9'h002, 9'h007, 9'h1a0, 9'h120};

  always #10 clk = ~clk;

  crt_refresh u_dut (.clk, .rst_b, .port_select, .rd_b, .wr_b, .cs_b, .row_buffer_select_b, .data_lines_in,
    .data_lines_out, .data_lines_oe, .row_buffer_ready, .interrupt, .line_count, .char_code, .horiz_retrace,
    .vert_retrace, .video_suppress, .light_enable, .highlight, .general_attr);
  crt_host_model u_host (.clk, .data_lines_out, .data_lines_oe, .port_select, .rd_b, .wr_b, .cs_b,
    .row_buffer_select_b, .data_lines_in);

  // ****************************************
  // helpers
  // ****************************************
  task automatic chk(input string nm, input logic [7:0] ex, input logic [7:0] got, input logic [7:0] m = 8'hff);
    num_checks++;
    if (((got ^ ex) & m) !== 8'h00)
    begin
      error_cnt++;
      $display("Error %s expected %h seen %h", nm, ex & m, got & m);
    end
  endtask

  task conclude;
    $display("checks %0d errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  function automatic logic [31:0] xs(input logic [31:0] x);
    x = x ^ (x << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction

  function automatic logic sig(input int k);
    return k == 0 ? horiz_retrace : vert_retrace;
  endfunction

  task automatic wait_for(input int k, input logic v);
    int i;
    for (i = 0; i < 500 && sig(k) !== v; i++) @(negedge clk);
    if (i == 500) chk("wait_timeout", 8'h00, 8'h01);
  endtask

  task automatic run(input int k, input logic v, output int c);
    c = 0;
    while (sig(k) === v && c < 500)
    begin
      @(negedge clk);
      c++;
    end
  endtask

  task automatic rd(input logic ps, input logic [7:0] ex, input logic [7:0] m);
    exp_q.push_back({ex, m});
    u_host.acc(ps, 1'b0, 1'b1, 1'b1, 8'h00);
  endtask

  // one attribute byte then seven characters per row, two spare cycles per write
  task automatic load(input int cyc);
    repeat (cyc)
    begin
      if (row_buffer_ready === 1'b1)
      begin
        u_host.acc(1'b0, 1'b1, 1'b0, 1'b0, li % 8 == 0 ? {4'h8, gpa, 2'b01} : {1'b0, ch});
        li++;
        repeat (2) @(posedge clk);
      end
      else
        @(posedge clk);
    end
  endtask

  // ****************************************
  // result watcher
  // ****************************************
  always @(negedge clk)
  begin
    if (data_lines_oe === 1'b1 && oe_q !== 1'b1)
    begin
      if (exp_q.size() == 0)
        chk("unexpected_read", 8'h00, 8'h01);
      else
      begin
        e = exp_q.pop_front();
        chk("read_data", e[15:8], data_lines_out, e[7:0]);
      end
    end
    if (mon_on)
    begin
      if (line_count > max_lc) max_lc = line_count;
      if ({horiz_retrace, vert_retrace, video_suppress} === 3'b000)
      begin
        vis++;
        chk("char_code", {1'b0, ch}, {1'b0, char_code});
        chk("field_attr", {5'h0, gpa, 1'b1}, {5'h0, general_attr, highlight});
      end
    end
    oe_q = data_lines_oe;
  end

  // ****************************************
  // stimulus
  // ****************************************
  initial
  begin
    repeat (7) @(negedge clk);
    chk("reset_flags", 8'h01, {data_lines_oe, row_buffer_ready, interrupt, horiz_retrace, vert_retrace,
      light_enable, highlight, video_suppress});
    chk("reset_codes", 8'h00, {line_count, general_attr, 2'b00});
    @(posedge clk);
    #2 rst_b = 1'b1;
    repeat (2) @(posedge clk);
    u_host.acc(1'b1, 1'b1, 1'b1, 1'b0, 8'h20);
    rd(1'b1, 8'h00, 8'h04);
    u_host.acc(1'b1, 1'b1, 1'b1, 1'b1, 8'h00);
    rd(1'b0, 8'h00, 8'hff);
    chk("ready_idle", 8'h00, {7'h0, row_buffer_ready});
    $display("test host_port done");
    foreach (cfg[k]) u_host.acc(cfg[k][8], 1'b0, 1'b1, 1'b0, cfg[k][7:0]);
    rd(1'b1, 8'h14, 8'h14);
    wait_for(0, 1'b0);
    wait_for(0, 1'b1);
    run(0, 1'b1, n);
    chk("hret_len", 8'd8, 8'(n));
    run(0, 1'b0, n);
    chk("row_chars", 8'd8, 8'(n));
    wait_for(1, 1'b0);
    wait_for(1, 1'b1);
    run(1, 1'b1, n);
    chk("vret_len", 8'd48, 8'(n));
    chk("int_set", 8'h01, {7'h0, interrupt});
    rd(1'b1, 8'h1c, 8'h1c);
    repeat (3) @(posedge clk);
    chk("int_clear", 8'h00, {7'h0, interrupt});
    u_host.acc(1'b1, 1'b0, 1'b1, 1'b0, 8'hc0);
    wait_for(1, 1'b1);
    run(1, 1'b1, n);
    chk("int_masked", 8'h00, {7'h0, interrupt});
    $display("test raster done");
    rs = xs(rs);
    ch = rs[6:0];
    gpa = rs[9:8];
    mon_on = 1'b1;
    load(600);
    mon_on = 1'b0;
    chk("rows_loaded", 8'h01, {7'h0, li > 0});
    chk("visible", 8'h01, {7'h0, vis > 0});
    chk("line_max", 8'h02, {4'h0, max_lc});
    $display("test display done");
    repeat (300) @(posedge clk);
    rd(1'b1, 8'h02, 8'h02);
    chk("blank_underrun", 8'h01, {7'h0, video_suppress});
    u_host.acc(1'b1, 1'b0, 1'b1, 1'b0, 8'h40);
    rd(1'b1, 8'h00, 8'h04);
    repeat (3) @(posedge clk);
    chk("ready_stop", 8'h00, {7'h0, row_buffer_ready});
    chk("vsp_stop", 8'h01, {7'h0, video_suppress});
    chk("reads_left", 8'h00, 8'(exp_q.size()));
    $display("test underrun_stop done");
    conclude;
  end

  initial
  begin
    #200000;
    chk("watchdog", 8'h00, 8'h01);
    conclude;
  end
endmodule // testbench

bind crt_refresh crt_refresh_sva u_sva (.clk, .rst_b, .port_select, .rd_b, .wr_b, .cs_b, .row_buffer_select_b,
  .data_lines_out, .data_lines_oe, .line_count, .horiz_retrace, .vert_retrace, .video_suppress, .light_enable);
